// ===== ckgcfg_top.sv
`timescale 1ns/1ps
`default_nettype none
module ckgcfg_top (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Serial bus, open drain data
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Control pin
  input  wire logic       multifunction_control_pin,
  // Clock sources
  input  wire logic       synth_loop_one,
  input  wire logic       synth_loop_two,
  input  wire logic       synth_loop_three,
  input  wire logic       external_reference_input,
  // Clock outputs and pad controls
  output logic            clock_output_one,
  output logic            clock_output_two,
  output logic            clock_output_three,
  output logic [2:0]      out_drive_en,
  output logic [2:0]      out_pulldown_en,
  output logic [1:0]      drive_one,
  output logic [1:0]      drive_two,
  output logic [1:0]      drive_three,
  // Synthesizer control
  output logic [2:0]      synth_enable,
  output logic            spread_modulation_two_en,
  output logic            spread_modulation_three_en,
  output logic            chip_powerdown
);
  ckgcfg_pkg::ckgcfg_state_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] register_pointer_byte_q, register_pointer_byte_d;
  logic       rw_q, rw_d;
  logic       ack_q, ack_d;
  logic       oe_q, oe_d;
  logic       scl_p_q, sda_p_q;
  logic       wr_en;
  logic       cfg_clear;
  logic [2:0] pins_s;
  logic       scl_s, sda_s, pin_s;
  logic       start_ev, stop_ev, scl_rise, scl_fall;
  logic       pd_active;
  logic [7:0] rd_data;
  logic [7:0] cfg_mem [0:255];
  logic [7:0] reg_src, reg_drv, reg_ctl, reg_en;
  logic [3:0] sources;
  logic [2:0] out_enable;
  logic [2:0] clk_vec;

  // Pins cross into sys_clk; 52+ clocks per low phase at 400 kbit/s
  ckgcfg_sync #(.W(3)) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in ({multifunction_control_pin, sda_in, scl_in}),
    .sync_out (pins_s)
  );
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign pin_s = pins_s[2];

  // Previous synchronised levels for edge detection
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Start and stop only count while the clock stays high
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;

  // Named registers out of the array
  assign reg_src = cfg_mem[ckgcfg_pkg::OFS_SOURCE];
  assign reg_drv = cfg_mem[ckgcfg_pkg::OFS_DRIVE];
  assign reg_ctl = cfg_mem[ckgcfg_pkg::OFS_CONTROL];
  assign reg_en  = cfg_mem[ckgcfg_pkg::OFS_OUT_EN];
  assign rd_data = cfg_mem[register_pointer_byte_q];

  // Powerdown mode with the pin low; keep-alive decides whether state survives
  assign pd_active = ~reg_ctl[ckgcfg_pkg::CTL_PIN_OE] & ~pin_s;
  assign cfg_clear = pd_active & ~reg_ctl[ckgcfg_pkg::CTL_KEEP];

  // Serial state machine: sample on rising, drive on falling clock
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    tx_d  = tx_q;
    rw_d  = rw_q;
    ack_d = ack_q;
    oe_d  = oe_q;
    wr_en = 1'b0;
    register_pointer_byte_d = register_pointer_byte_q;
    if (pd_active) begin
      st_d = ckgcfg_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else if (start_ev) begin
      st_d  = ckgcfg_pkg::ST_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else if (stop_ev) begin
      st_d = ckgcfg_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      if (st_q == ckgcfg_pkg::ST_ADDR || st_q == ckgcfg_pkg::ST_PTR ||
          st_q == ckgcfg_pkg::ST_WDATA) begin
        sh_d  = {sh_q[6:0], sda_s};
        cnt_d = cnt_q + 4'h1;
      end else if (st_q == ckgcfg_pkg::ST_RDATA) begin
        cnt_d = cnt_q + 4'h1;
      end else if (st_q == ckgcfg_pkg::ST_RACK) begin
        ack_d = ~sda_s;
      end
    end else if (scl_fall) begin
      unique case (st_q)
        ckgcfg_pkg::ST_ADDR: begin
          if (cnt_q == ckgcfg_pkg::BYTE_BITS) begin
            if (sh_q[7:1] == ckgcfg_pkg::TARGET_ADDR) begin
              st_d = ckgcfg_pkg::ST_AACK;
              oe_d = 1'b1;
              rw_d = sh_q[0];
            end else begin
              st_d = ckgcfg_pkg::ST_IDLE;
            end
          end
        end
        ckgcfg_pkg::ST_AACK: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            tx_d = rd_data;
            oe_d = ~rd_data[7];
            st_d = ckgcfg_pkg::ST_RDATA;
            register_pointer_byte_d = register_pointer_byte_q + 8'h01;
          end else begin
            oe_d = 1'b0;
            st_d = ckgcfg_pkg::ST_PTR;
          end
        end
        ckgcfg_pkg::ST_PTR: begin
          if (cnt_q == ckgcfg_pkg::BYTE_BITS) begin
            register_pointer_byte_d = sh_q;
            st_d = ckgcfg_pkg::ST_PACK;
            oe_d = 1'b1;
          end
        end
        ckgcfg_pkg::ST_PACK, ckgcfg_pkg::ST_WACK: begin
          oe_d  = 1'b0;
          cnt_d = 4'h0;
          st_d  = ckgcfg_pkg::ST_WDATA;
        end
        ckgcfg_pkg::ST_WDATA: begin
          if (cnt_q == ckgcfg_pkg::BYTE_BITS) begin
            wr_en = 1'b1;
            register_pointer_byte_d = register_pointer_byte_q + 8'h01;
            st_d = ckgcfg_pkg::ST_WACK;
            oe_d = 1'b1;
          end
        end
        ckgcfg_pkg::ST_RDATA: begin
          if (cnt_q == ckgcfg_pkg::BYTE_BITS) begin
            oe_d = 1'b0;
            st_d = ckgcfg_pkg::ST_RACK;
          end else begin
            tx_d = {tx_q[6:0], 1'b0};
            oe_d = ~tx_q[6];
          end
        end
        ckgcfg_pkg::ST_RACK: begin
          if (ack_q) begin
            tx_d  = rd_data;
            oe_d  = ~rd_data[7];
            cnt_d = 4'h0;
            st_d  = ckgcfg_pkg::ST_RDATA;
            register_pointer_byte_d = register_pointer_byte_q + 8'h01;
          end else begin
            st_d = ckgcfg_pkg::ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q  <= ckgcfg_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      sh_q  <= 8'h00;
      tx_q  <= 8'h00;
      rw_q  <= 1'b0;
      ack_q <= 1'b0;
      oe_q  <= 1'b0;
      register_pointer_byte_q <= 8'h00;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      tx_q  <= tx_d;
      rw_q  <= rw_d;
      ack_q <= ack_d;
      oe_q  <= oe_d;
      register_pointer_byte_q <= register_pointer_byte_d;
    end
  end

  // Open drain: only ever pull low, changed one clock after a falling edge
  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;

  // Volatile array; a powerdown without keep-alive restores every default
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 256; i++) begin
        cfg_mem[i] <= ckgcfg_pkg::RST_OTHER;
      end
      cfg_mem[ckgcfg_pkg::OFS_SOURCE]  <= ckgcfg_pkg::RST_SOURCE;
      cfg_mem[ckgcfg_pkg::OFS_DRIVE]   <= ckgcfg_pkg::RST_DRIVE;
      cfg_mem[ckgcfg_pkg::OFS_CONTROL] <= ckgcfg_pkg::RST_CONTROL;
      cfg_mem[ckgcfg_pkg::OFS_OUT_EN]  <= ckgcfg_pkg::RST_OUT_EN;
    end else if (cfg_clear) begin
      for (int i = 0; i < 256; i++) begin
        cfg_mem[i] <= ckgcfg_pkg::RST_OTHER;
      end
      cfg_mem[ckgcfg_pkg::OFS_SOURCE]  <= ckgcfg_pkg::RST_SOURCE;
      cfg_mem[ckgcfg_pkg::OFS_DRIVE]   <= ckgcfg_pkg::RST_DRIVE;
      cfg_mem[ckgcfg_pkg::OFS_CONTROL] <= ckgcfg_pkg::RST_CONTROL;
      cfg_mem[ckgcfg_pkg::OFS_OUT_EN]  <= ckgcfg_pkg::RST_OUT_EN;
    end else if (wr_en) begin
      cfg_mem[register_pointer_byte_q] <= sh_q;
    end
  end

  // Per-output crossbar, enable gating and pad stage
  assign sources = {external_reference_input, synth_loop_three,
                    synth_loop_two, synth_loop_one};
  generate
    for (genvar g = 0; g < 3; g++) begin : g_out
      logic [1:0] sel;
      logic       sens;
      assign sel  = reg_src[g*ckgcfg_pkg::FIELD_W +: ckgcfg_pkg::FIELD_W];
      assign sens = reg_ctl[ckgcfg_pkg::CTL_SENS_LSB + g];
      // In enable mode the pin gates this output only if sensitive; in powerdown mode pin low gates every output
      assign out_enable[g] = reg_en[g] & ~pd_active &
        ~(reg_ctl[ckgcfg_pkg::CTL_PIN_OE] & sens & ~pin_s);
      ckgcfg_outstage u_stage (
        .sys_clk     (sys_clk),
        .reset_n     (reset_n),
        .src_clk     (sources[sel]),
        .enable      (out_enable[g]),
        .clk_out     (clk_vec[g]),
        .drive_en    (out_drive_en[g]),
        .pulldown_en (out_pulldown_en[g])
      );
    end
  endgenerate

  assign clock_output_one   = clk_vec[0];
  assign clock_output_two   = clk_vec[1];
  assign clock_output_three = clk_vec[2];
  assign drive_one   = reg_drv[1:0];
  assign drive_two   = reg_drv[3:2];
  assign drive_three = reg_drv[5:4];

  // Spread only exists on synths two and three
  assign spread_modulation_two_en   =
    reg_ctl[ckgcfg_pkg::CTL_SPREAD2] & ~pd_active;
  assign spread_modulation_three_en =
    reg_ctl[ckgcfg_pkg::CTL_SPREAD3] & ~pd_active;
  assign synth_enable   = {3{~pd_active}};
  assign chip_powerdown = pd_active;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence seq_addr_done;
    !pd_active && !start_ev && !stop_ev && scl_fall &&
    st_q == ckgcfg_pkg::ST_ADDR && cnt_q == ckgcfg_pkg::BYTE_BITS;
  endsequence
  sequence seq_ptr_done;
    !pd_active && !start_ev && !stop_ev && scl_fall &&
    st_q == ckgcfg_pkg::ST_PTR && cnt_q == ckgcfg_pkg::BYTE_BITS;
  endsequence

  AST_ADDR_ACK: assert property (
    seq_addr_done ##0 (sh_q[7:1] == ckgcfg_pkg::TARGET_ADDR) |=>
      sda_oe && st_q == ckgcfg_pkg::ST_AACK)
    else $error("own address not acknowledged");
  AST_FOREIGN_IGNORED: assert property (
    seq_addr_done ##0 (sh_q[7:1] != ckgcfg_pkg::TARGET_ADDR) |=>
      !sda_oe && st_q == ckgcfg_pkg::ST_IDLE)
    else $error("foreign address answered");
  AST_PTR_LOAD: assert property (
    seq_ptr_done |=> register_pointer_byte_q == $past(sh_q) && !wr_en
      && sda_oe)
    else $error("pointer byte not loaded");
  AST_WRITE_ADVANCE: assert property (
    wr_en |=> register_pointer_byte_q == $past(register_pointer_byte_q)
      + 8'h01 && cfg_mem[$past(register_pointer_byte_q)] == $past(sh_q))
    else $error("write did not store and advance");
  AST_PTR_WRAP: assert property (
    wr_en && register_pointer_byte_q == 8'hff |=>
      register_pointer_byte_q == 8'h00)
    else $error("pointer failed to wrap");
  AST_START_SEEN: assert property (
    start_ev && !pd_active |=> st_q == ckgcfg_pkg::ST_ADDR && cnt_q == 4'h0)
    else $error("start condition missed");
  AST_READ_BIT: assert property (
    !pd_active && !start_ev && !stop_ev && scl_fall &&
    st_q == ckgcfg_pkg::ST_RDATA && cnt_q < ckgcfg_pkg::BYTE_BITS |=>
      sda_oe == ~$past(tx_q[6]))
    else $error("wrong read bit driven");
  AST_SDA_STABLE_HIGH: assert property (
    scl_s && scl_p_q && !pd_active && !$past(pd_active) |->
      $stable(sda_oe))
    else $error("data changed while clock high");
  AST_POWERDOWN: assert property (
    pd_active |-> synth_enable == 3'h0 && out_enable == 3'h0 ##1 !sda_oe)
    else $error("powerdown left chip running");
endmodule
`default_nettype wire

// ===== ckgcfg_pkg.sv
// How it works
// - Answer only target address 0x69 sent after each start, direction flag in LSB.
// - Write is address, ack, register pointer byte, ack, then acked data bytes, stop.
// - Data line changes only while the serial clock is low, except start/stop.
// - Data falling with clock high is start; data rising with clock high is stop.
// - Device pulls data low on the ninth clock of every byte it receives.
// - Multi-byte writes store each byte and advance the pointer until stop.
// - A read starts like a write but with the direction flag set to one.
// - Pointer stays one past last accessed location; current read returns next one.
// - Read address is acked, a byte is sent; no ack plus stop ends sending.
// - Pointer-only write then repeated start loads the pointer and stores nothing.
// - Master ack after a read byte advances the pointer and sends the next byte.
// - Pointer wraps from 0xff to 0x00.
// - Reads and writes work at serial rates up to 400 kbit/s.
// - Registers take defaults at power-up; written values are volatile.
// - Each of three outputs selects one of four sources: three synths or reference.
// - Control pin acts as active-low powerdown or as output enable.
// - Pin low in powerdown mode stops the chip; high resumes, with defaults unless keep-alive is set.
// - A disabled output is driven low first, then released onto a weak pull-down.
// - In enable mode each output has its own bit making it follow the pin.
// - Keep-alive retains registers over powerdown; without it they are lost.
// - Only synths two and three have spread modulation, each with its own switch.
package ckgcfg_pkg;
  localparam logic [6:0] TARGET_ADDR   = 7'h69;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  // Register offsets
  localparam logic [7:0] OFS_SOURCE    = 8'h00;
  localparam logic [7:0] OFS_DRIVE     = 8'h01;
  localparam logic [7:0] OFS_CONTROL   = 8'h02;
  localparam logic [7:0] OFS_OUT_EN    = 8'h03;
  // Reset values
  localparam logic [7:0] RST_SOURCE    = 8'h24;
  localparam logic [7:0] RST_DRIVE     = 8'h00;
  localparam logic [7:0] RST_CONTROL   = 8'h70;
  localparam logic [7:0] RST_OUT_EN    = 8'h07;
  localparam logic [7:0] RST_OTHER     = 8'h00;
  // Control register fields, then source select field width
  localparam int         CTL_PIN_OE    = 0;
  localparam int         CTL_KEEP      = 1;
  localparam int         CTL_SPREAD2   = 2;
  localparam int         CTL_SPREAD3   = 3;
  localparam int         CTL_SENS_LSB  = 4;
  localparam int         FIELD_W       = 2;
  // Output drive-low hold before release
  localparam int         CLK_PERIOD_NS = 25;
  localparam int         LOW_HOLD_NS   = 100;
  localparam logic [2:0] LOW_HOLD_CYC  =
    3'((LOW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Serial clock low phase at 400 kbit/s, in system clocks (rounded down)
  localparam int         SCL_LOW_NS    = 1300;
  localparam int         SCL_LOW_CYC   = SCL_LOW_NS / CLK_PERIOD_NS;
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_PTR   = 9'h008,
    ST_PACK  = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } ckgcfg_state_type;
endpackage

// ===== ckgcfg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ckgcfg_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // Pins
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // Idle bus lines and the control pin rest high, so reset to ones
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// ===== ckgcfg_outstage.sv
`timescale 1ns/1ps
`default_nettype none
module ckgcfg_outstage (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Source and control
  input  wire logic src_clk,
  input  wire logic enable,
  // Pad controls
  output logic      clk_out,
  output logic      drive_en,
  output logic      pulldown_en
);
  logic       run_q;
  logic       run_d;
  logic       drv_q;
  logic       drv_d;
  logic [2:0] hold_q;
  logic [2:0] hold_d;

  // Stop the clock first, keep driving low a while, then hand over to pull-down
  always_comb begin
    run_d  = enable;
    hold_d = hold_q;
    drv_d  = drv_q;
    if (enable) begin
      drv_d  = 1'b1;
      hold_d = ckgcfg_pkg::LOW_HOLD_CYC;
    end else if (hold_q != 3'h0) begin
      hold_d = hold_q - 3'h1;
      drv_d  = 1'b1;
    end else begin
      drv_d  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q  <= 1'b0;
      drv_q  <= 1'b0;
      hold_q <= 3'h0;
    end else begin
      run_q  <= run_d;
      drv_q  <= drv_d;
      hold_q <= hold_d;
    end
  end

  // Gating with a flop keeps the output low while the driver is still on
  assign clk_out     = src_clk & run_q;
  assign drive_en    = drv_q;
  assign pulldown_en = ~drv_q;
endmodule
`default_nettype wire

// ===== ckgcfg_master.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master model; its clock stands high between frames
module ckgcfg_master (
  // Bus lines
  output var logic scl,
  output var logic sda_low,
  input  wire logic sda_line
);
  // Both lines start released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data falls while the clock is high; also a repeated start
  task automatic start();
    #30 sda_low = 1'b0;
    #100 scl = 1'b1;
    #100 sda_low = 1'b1;
    #100 scl = 1'b0;
  endtask
  // Data rises while the clock is high
  task automatic stop();
    #30 sda_low = 1'b1;
    #100 scl = 1'b1;
    #100 sda_low = 1'b0;
    #100;
  endtask
  // Data moves in the low phase only; read late in the high phase,
  // since the target answers a few system clocks after our fall
  task automatic bit_cycle(input logic b, output logic s);
    #30 sda_low = ~b;
    #100 scl = 1'b1;
    #65 s = sda_line;
    #5 scl = 1'b0;
  endtask
  // Byte out MSB first, then the target's acknowledge slot
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask
  // Byte in; acknowledge to go on, leave released to end
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(~more, s);
  endtask
endmodule
`default_nettype wire

// ===== ckgcfg_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ckgcfg_top_tb;
  localparam logic [7:0] AW = {ckgcfg_pkg::TARGET_ADDR, 1'b0};
  localparam logic [7:0] AR = {ckgcfg_pkg::TARGET_ADDR, 1'b1};
  localparam logic [7:0] CTL = ckgcfg_pkg::OFS_CONTROL;
  // Stimulus and observed pins
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        pin     = 1'b1;
  logic [3:0]  src     = 4'h0;
  wire logic   scl, sda_low, sda_line;
  logic        sda_out, sda_oe, c1, c2, c3, pdn, sp2, sp3;
  logic [2:0]  den, pden, sen;
  logic [1:0]  dr1, dr2, dr3;
  logic [7:0]  mem [256];
  logic [7:0]  ptr;
  logic [31:0] lfsr = 32'h6ea7a3be;
  int          fail_count = 0;
  int          cmp_count = 0;
  // Open-drain data line with pull-up
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
  // System clock
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  ckgcfg_top i_ckgcfg_top (
    .sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .multifunction_control_pin(pin), .synth_loop_one(src[0]),
    .synth_loop_two(src[1]), .synth_loop_three(src[2]),
    .external_reference_input(src[3]), .clock_output_one(c1),
    .clock_output_two(c2), .clock_output_three(c3),
    .out_drive_en(den), .out_pulldown_en(pden), .drive_one(dr1),
    .drive_two(dr2), .drive_three(dr3), .synth_enable(sen),
    .spread_modulation_two_en(sp2),
    .spread_modulation_three_en(sp3), .chip_powerdown(pdn));
  ckgcfg_master i_ckgcfg_master (
    .scl(scl), .sda_low(sda_low), .sda_line(sda_line));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
    return lfsr[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Inputs move a fixed 2 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic set_pin(input logic v);
    cyc(1);
    pin = v;
    cyc(12);
  endtask
  // Reference copy of the array at its defaults
  task automatic init_mem();
    foreach (mem[i]) mem[i] = ckgcfg_pkg::RST_OTHER;
    mem[ckgcfg_pkg::OFS_SOURCE] = ckgcfg_pkg::RST_SOURCE;
    mem[ckgcfg_pkg::OFS_DRIVE] = ckgcfg_pkg::RST_DRIVE;
    mem[CTL] = ckgcfg_pkg::RST_CONTROL;
    mem[ckgcfg_pkg::OFS_OUT_EN] = ckgcfg_pkg::RST_OUT_EN;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    logic a;
    i_ckgcfg_master.start();
    i_ckgcfg_master.send_byte(AW, a);
    check(8'(a), 8'h01);
    i_ckgcfg_master.send_byte(p, a);
    check(8'(a), 8'h01);
    ptr = p;
    foreach (d[i]) begin
      i_ckgcfg_master.send_byte(d[i], a);
      check(8'(a), 8'h01);
      mem[ptr] = d[i];
      ptr++;
    end
    i_ckgcfg_master.stop();
  endtask
  // Read n bytes, from a new pointer or from the current one
  task automatic rd(input logic setp, input logic [7:0] p, input int n);
    logic a;
    logic [7:0] d;
    if (setp) begin
      i_ckgcfg_master.start();
      i_ckgcfg_master.send_byte(AW, a);
      i_ckgcfg_master.send_byte(p, a);
      ptr = p;
    end
    i_ckgcfg_master.start();
    i_ckgcfg_master.send_byte(AR, a);
    check(8'(a), 8'h01);
    for (int i = 0; i < n; i++) begin
      i_ckgcfg_master.recv_byte(i < n - 1, d);
      check(d, mem[ptr]);
      ptr++;
    end
    i_ckgcfg_master.stop();
  endtask
  // Output three must go low while still driven, then be let go
  task automatic watch();
    int n;
    n = 0;
    while (c3 === 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
    if (n == 4000) begin
      fail_count++;
      test_done();
    end
    check(8'(den[2]), 8'h01);
    n = 0;
    while (den[2] === 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    check(8'(n), 8'(ckgcfg_pkg::LOW_HOLD_CYC));
    check(8'({pden[2], c3}), 8'h02);
  endtask
  // Hang guard
  initial begin
    #1_000_000;
    fail_count++;
    test_done();
  end
  // Main sequence
  initial begin
    logic a;
    logic [7:0] d, s, p;
    init_mem();
    repeat (16) @(posedge sys_clk);
    #2 reset_n = 1'b1;
    cyc(8);
    check(8'({pdn, sp3, sp2, sen}), 8'h07);
    rd(1'b1, 8'h00, 4);
    $display("test defaults done");
    p = 8'h10 + (rnd() & 8'h7f);
    wr(p, {rnd(), rnd(), rnd()});
    rd(1'b1, p, 3);
    rd(1'b0, 8'h00, 1);
    wr(8'hff, {rnd(), 8'h24});
    rd(1'b1, 8'hfe, 4);
    rd(1'b0, 8'h00, 1);
    $display("test pointer done");
    i_ckgcfg_master.start();
    i_ckgcfg_master.send_byte(AW ^ 8'h02, a);
    check(8'(a), 8'h00);
    i_ckgcfg_master.send_byte(8'h00, a);
    check(8'(a), 8'h00);
    i_ckgcfg_master.stop();
    rd(1'b0, 8'h00, 1);
    $display("test foreign done");
    for (int i = 0; i < 8; i++) begin
      s = (i < 4) ? {2'b00, 2'(i), 2'(i), 2'(i)} : rnd() & 8'h3f;
      d = rnd();
      wr(ckgcfg_pkg::OFS_SOURCE, {s});
      cyc(1);
      src = (i < 4) ? 4'(1 << i) : d[3:0];
      cyc(2);
      check(8'({c3, c2, c1}),
            8'({src[s[5:4]], src[s[3:2]], src[s[1:0]]}));
    end
    d = rnd();
    wr(ckgcfg_pkg::OFS_DRIVE, {d});
    cyc(2);
    check(8'({dr3, dr2, dr1}), 8'(d[5:0]));
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 8'h74 : 8'h78;
      wr(CTL, {d});
      cyc(2);
      check(8'({sp3, sp2}), 8'(d[3:2]));
    end
    $display("test fields done");
    wr(ckgcfg_pkg::OFS_SOURCE, {8'h24});
    cyc(1);
    src = 4'hf;
    fork
      wr(ckgcfg_pkg::OFS_OUT_EN, {8'h03});
      watch();
    join
    wr(ckgcfg_pkg::OFS_OUT_EN, {8'h07});
    wr(CTL, {8'h51});
    set_pin(1'b0);
    check(8'(den), 8'h02);
    check(8'({pdn, sen}), 8'h07);
    set_pin(1'b1);
    check(8'(den), 8'h07);
    $display("test enables done");
    wr(CTL, {8'h74});
    wr(ckgcfg_pkg::OFS_DRIVE, {8'h3f});
    set_pin(1'b0);
    check(8'({pdn, sp2, sen, den}), 8'h80);
    set_pin(1'b1);
    init_mem();
    check(8'({pdn, sen}), 8'h07);
    rd(1'b1, 8'h00, 4);
    d = rnd();
    wr(CTL, {8'h72});
    wr(ckgcfg_pkg::OFS_DRIVE, {d});
    set_pin(1'b0);
    check(8'({pdn, sen}), 8'h08);
    set_pin(1'b1);
    rd(1'b1, 8'h01, 2);
    $display("test powerdown done");
    test_done();
  end
endmodule
`default_nettype wire
